// ### nor_host_pkg.sv
package nor_host_pkg;

  // ****************************************************************
  // widths and array geometry
  // ****************************************************************
  localparam int AW        = 22;            // 4,194,304 byte addresses
  localparam int DW        = 8;             // byte-wide data lines
  localparam int NSEC      = 64;            // sixty-four sectors
  localparam int SEC_SHIFT = 16;            // 64 Kbyte per sector
  localparam int TOGGLE_BIT = 6;            // toggle status bit position
  localparam int POLL_BIT   = 7;            // polling status bit position

  typedef logic [AW-1:0] faddr_t;
  typedef logic [DW-1:0] byte_t;
  typedef logic [7:0]    cnt_t;
  typedef logic [5:0]    sec_t;
  typedef logic [2:0]    step_t;

  localparam sec_t  SEC_LAST  = 6'h3f;
  localparam cnt_t  CNT_ONE   = 8'h01;
  localparam step_t STEP_ZERO = 3'h0;
  localparam step_t STEP_ONE  = 3'h1;

  // ****************************************************************
  // timing, printed figures in ns and derived clock counts
  // ****************************************************************
  localparam int CLK_NS   = 8;              // 125 MHz mclk
  localparam int T_ACC_NS = 70;             // read access time
  localparam int T_WP_NS  = 35;             // write strobe low time
  localparam int T_WPH_NS = 30;             // strobe high recovery
  localparam int T_RP_NS  = 500;            // reset pin low time
  localparam int T_RH_NS  = 50;             // reset release to first cycle
  localparam cnt_t ACC_CNT = cnt_t'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t WP_CNT  = cnt_t'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t WPH_CNT = cnt_t'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t RP_CNT  = cnt_t'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t RH_CNT  = cnt_t'((T_RH_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // command cycle codes and unlock addresses
  // ****************************************************************
  localparam faddr_t UNLOCK_A1 = 22'h000555;
  localparam faddr_t UNLOCK_A2 = 22'h0002aa;
  localparam byte_t  CD_UNLK1  = 8'haa;
  localparam byte_t  CD_UNLK2  = 8'h55;
  localparam byte_t  CD_PROG   = 8'ha0;
  localparam byte_t  CD_ERASE  = 8'h80;
  localparam byte_t  CD_SECTOR = 8'h30;
  localparam byte_t  CD_SUSP   = 8'hb0;
  localparam byte_t  CD_RESUME = 8'h30;
  localparam byte_t  CD_BYP_IN = 8'h20;
  localparam byte_t  CD_BYP_X1 = 8'h90;
  localparam byte_t  CD_BYP_X2 = 8'h00;
  localparam byte_t  CD_RESET  = 8'hf0;

  // ****************************************************************
  // user operations
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_SUSPEND, OP_RESUME,
    OP_BYP_ENTER, OP_BYP_EXIT, OP_SOFT_RESET, OP_HW_RESET
  } op_t;

endpackage

// ### cycle_if.sv
`timescale 1ns/1ps
// one bus cycle request from the sequencer to the pin engine
interface cycle_if;
  import nor_host_pkg::*;
  logic   req;
  logic   wr;
  faddr_t addr;
  byte_t  wdata;
  logic   ack;
  byte_t  rdata;
  modport ctrl   (output req, wr, addr, wdata, input ack, rdata);
  modport engine (input req, wr, addr, wdata, output ack, rdata);
endinterface

// ### bus_cycle_engine.sv
`timescale 1ns/1ps
module bus_cycle_engine (
  input  wire logic                 mclk,          // system clock
  input  wire logic                 rst_n,         // synchronised reset
  cycle_if.engine                   cyc,           // cycle requests
  output logic [nor_host_pkg::AW-1:0] flash_addr,  // address lines
  output logic [nor_host_pkg::DW-1:0] data_lines_out, // write data
  input  wire logic [nor_host_pkg::DW-1:0] data_lines_in, // read data
  output logic                      data_lines_oe_n, // low while driving
  output logic                      flash_ce_n,    // chip select
  output logic                      flash_we_n,    // write strobe
  output logic                      flash_oe_n     // read strobe
);
  import nor_host_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} est_t;
  typedef struct packed {
    est_t   st;
    cnt_t   cnt;
    logic   wr;
    faddr_t addr;
    byte_t  wdata;
    byte_t  rdata;
    logic   ack;
    logic   ce_n;
    logic   we_n;
    logic   oe_n;
    logic   dq_oe_n;
  } eng_t;

  eng_t q, d;

  // one strobe cycle: setup, pulse, recovery, then a one-cycle ack
  always_comb begin
    d     = q;
    d.ack = 1'b0;
    case (q.st)
      E_IDLE: begin
        // ack cycle blocks re-accepting the request that just finished
        if (cyc.req && !q.ack) begin
          d.wr      = cyc.wr;
          d.addr    = cyc.addr;
          d.wdata   = cyc.wdata;
          d.ce_n    = 1'b0;
          d.dq_oe_n = !cyc.wr;
          d.st      = E_SETUP;
        end
      end
      E_SETUP: begin
        if (q.wr) begin
          d.we_n = 1'b0;
          d.cnt  = WP_CNT;
        end else begin
          d.oe_n = 1'b0;
          d.cnt  = ACC_CNT;
        end
        d.st = E_PULSE;
      end
      E_PULSE: begin
        d.cnt = q.cnt - CNT_ONE;
        if (q.cnt == CNT_ONE) begin
          d.we_n = 1'b1;
          d.oe_n = 1'b1;
          if (!q.wr) begin
            d.rdata = data_lines_in;             // sampled before strobe rises
          end
          d.cnt = WPH_CNT;
          d.st  = E_HOLD;
        end
      end
      E_HOLD: begin
        d.ce_n    = 1'b1;
        d.dq_oe_n = 1'b1;
        d.cnt     = q.cnt - CNT_ONE;
        if (q.cnt == CNT_ONE) begin
          d.ack = 1'b1;
          d.st  = E_IDLE;
        end
      end
      default: d.st = E_IDLE;
    endcase
  end

  // address is left where it was so an idle device can fall asleep
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: E_IDLE, cnt: '0, wr: 1'b0, addr: '0, wdata: '0, rdata: '0,
             ack: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign cyc.ack         = q.ack;
  assign cyc.rdata       = q.rdata;
  assign flash_addr      = q.addr;
  assign data_lines_out  = q.wdata;
  assign data_lines_oe_n = q.dq_oe_n;
  assign flash_ce_n      = q.ce_n;
  assign flash_we_n      = q.we_n;
  assign flash_oe_n      = q.oe_n;

endmodule

// ### nor_flash_host.sv
`timescale 1ns/1ps
// What this block does
// - chip select, write strobe and read strobe are separate and the read strobe is only used for reads.
// - commands are written as plain write cycles carrying both an address and a data byte.
// - in the shortened programming mode a byte program takes two write cycles instead of four.
// - the host can put the device into standby with its bus controls.
module nor_flash_host (
  input  wire logic                        mclk,            // 125 MHz clock
  input  wire logic                        rstn,            // async reset, active low
  input  wire logic                        cmd_valid,       // operation request
  output logic                             cmd_ready,       // ready for a request
  input  wire nor_host_pkg::op_t           cmd_op,          // operation code
  input  wire logic [nor_host_pkg::AW-1:0] cmd_addr,        // byte address
  input  wire logic [nor_host_pkg::DW-1:0] cmd_wdata,       // program data
  input  wire logic [nor_host_pkg::NSEC-1:0] cmd_sector_mask, // sectors to erase
  output logic                             rsp_valid,       // completion pulse
  output logic [nor_host_pkg::DW-1:0]      rsp_rdata,       // read or final status byte
  output logic                             rsp_error,       // verify or argument error
  output logic                             bypass_active,   // shortened mode on
  output logic [nor_host_pkg::AW-1:0]      flash_addr,      // device address lines
  output logic [nor_host_pkg::DW-1:0]      data_lines_out,  // device data, driven
  input  wire logic [nor_host_pkg::DW-1:0] data_lines_in,   // device data, sampled
  output logic                             data_lines_oe_n, // low while driving
  output logic                             flash_ce_n,      // chip select
  output logic                             flash_we_n,      // write strobe
  output logic                             flash_oe_n,      // read strobe
  output logic                             flash_reset_n,   // device reset pin
  input  wire logic                        ready_busy_out   // device ready/busy, high=ready
);
  import nor_host_pkg::*;

  // ****************************************************************
  // reset synchroniser
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // command word table
  // ****************************************************************
  // last write index of each sequence
  function automatic step_t seq_last(op_t op, logic byp);
    case (op)
      OP_PROG:      seq_last = byp ? STEP_ONE : 3'h3;
      OP_ERASE:     seq_last = 3'h4;
      OP_BYP_ENTER: seq_last = 3'h2;
      OP_BYP_EXIT:  seq_last = STEP_ONE;
      default:      seq_last = STEP_ZERO;
    endcase
  endfunction

  // address and data of one write of a sequence
  function automatic logic [AW+DW-1:0] seq_word(op_t op, logic byp, step_t s,
                                                faddr_t a, byte_t wd);
    seq_word = {UNLOCK_A1, CD_RESET};
    case (op)
      OP_PROG: begin
        if (byp) begin
          seq_word = (s == STEP_ZERO) ? {UNLOCK_A1, CD_PROG} : {a, wd};
        end else begin
          case (s)
            3'h0:    seq_word = {UNLOCK_A1, CD_UNLK1};
            3'h1:    seq_word = {UNLOCK_A2, CD_UNLK2};
            3'h2:    seq_word = {UNLOCK_A1, CD_PROG};
            default: seq_word = {a, wd};
          endcase
        end
      end
      OP_ERASE: begin
        case (s)
          3'h0, 3'h3: seq_word = {UNLOCK_A1, CD_UNLK1};
          3'h1, 3'h4: seq_word = {UNLOCK_A2, CD_UNLK2};
          default:    seq_word = {UNLOCK_A1, CD_ERASE};
        endcase
      end
      OP_BYP_ENTER: begin
        case (s)
          3'h0:    seq_word = {UNLOCK_A1, CD_UNLK1};
          3'h1:    seq_word = {UNLOCK_A2, CD_UNLK2};
          default: seq_word = {UNLOCK_A1, CD_BYP_IN};
        endcase
      end
      OP_BYP_EXIT:
        seq_word = (s == STEP_ZERO) ? {a, CD_BYP_X1} : {a, CD_BYP_X2};
      OP_SUSPEND:    seq_word = {a, CD_SUSP};
      OP_RESUME:     seq_word = {a, CD_RESUME};
      OP_SOFT_RESET: seq_word = {a, CD_RESET};
      default:       seq_word = {a, CD_RESET};
    endcase
  endfunction

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_WR, S_SECT, S_POLL, S_READ, S_RST, S_RST_WAIT
  } st_t;

  typedef struct packed {
    st_t              st;
    op_t              op;
    faddr_t           addr;
    byte_t            wdata;
    logic [NSEC-1:0]  mask;
    step_t            step;
    sec_t             sec;
    byte_t            prev;
    logic             have_prev;
    cnt_t             cnt;
    logic             rsp_valid;
    byte_t            rsp_rdata;
    logic             rsp_error;
    logic             bypass;
    logic             reset_n;
    logic             req;
    logic             wr;
    faddr_t           caddr;
    byte_t            cdata;
  } seq_t;

  seq_t q, d;
  cycle_if cyc ();

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (cmd_valid) begin
          d.op        = cmd_op;
          d.addr      = cmd_addr;
          d.wdata     = cmd_wdata;
          d.mask      = cmd_sector_mask;
          d.step      = STEP_ZERO;
          d.sec       = '0;
          d.have_prev = 1'b0;
          case (cmd_op)
            OP_READ: begin
              d.req   = 1'b1;
              d.wr    = 1'b0;
              d.caddr = cmd_addr;
              d.st    = S_READ;
            end
            OP_HW_RESET: begin
              d.reset_n = 1'b0;
              d.cnt     = RP_CNT;
              d.st      = S_RST;
            end
            default: begin
              if (cmd_op == OP_ERASE && cmd_sector_mask == '0) begin
                // nothing selected: answer at once rather than hang polling
                d.rsp_valid = 1'b1;
                d.rsp_error = 1'b1;
              end else begin
                d.req                = 1'b1;
                d.wr                 = 1'b1;
                {d.caddr, d.cdata}   = seq_word(cmd_op, q.bypass, STEP_ZERO,
                                                cmd_addr, cmd_wdata);
                d.st                 = S_WR;
              end
            end
          endcase
        end
      end
      S_WR: begin
        if (cyc.ack) begin
          if (q.step == seq_last(q.op, q.bypass)) begin
            d.req = 1'b0;
            case (q.op)
              OP_PROG: begin
                d.req   = 1'b1;
                d.wr    = 1'b0;
                d.caddr = q.addr;
                d.st    = S_POLL;
              end
              OP_ERASE: d.st = S_SECT;
              default: begin
                if (q.op == OP_BYP_ENTER) begin
                  d.bypass = 1'b1;
                end
                if (q.op == OP_BYP_EXIT || q.op == OP_SOFT_RESET) begin
                  d.bypass = 1'b0;
                end
                d.rsp_valid = 1'b1;
                d.rsp_error = 1'b0;
                d.st        = S_IDLE;
              end
            endcase
          end else begin
            d.step             = q.step + STEP_ONE;
            {d.caddr, d.cdata} = seq_word(q.op, q.bypass, d.step, q.addr, q.wdata);
          end
        end
      end
      // one sector write per selected mask bit, in ascending order
      S_SECT: begin
        if (q.req) begin
          if (cyc.ack) begin
            d.req = 1'b0;
            d.sec = q.sec + 6'h01;
          end
        end else if (q.mask[q.sec]) begin
          d.req   = 1'b1;
          d.wr    = 1'b1;
          d.caddr = faddr_t'(q.sec) << SEC_SHIFT;
          d.cdata = CD_SECTOR;
          d.addr  = faddr_t'(q.sec) << SEC_SHIFT;
        end else begin
          d.sec = q.sec + 6'h01;
        end
        if ((q.req && cyc.ack) || (!q.req && !q.mask[q.sec])) begin
          if (q.sec == SEC_LAST) begin
            d.req   = 1'b1;
            d.wr    = 1'b0;
            d.caddr = q.addr;
            d.st    = S_POLL;
          end
        end
      end
      // status reads until the toggle bit holds still and the pin says ready
      S_POLL: begin
        if (cyc.ack) begin
          if (q.have_prev && ready_busy_out &&
              q.prev[TOGGLE_BIT] == cyc.rdata[TOGGLE_BIT]) begin
            d.req       = 1'b0;
            d.rsp_valid = 1'b1;
            d.rsp_rdata = cyc.rdata;
            // a refused or failed operation leaves the old contents
            d.rsp_error = (q.op == OP_PROG) ? (cyc.rdata != q.wdata)
                                            : !cyc.rdata[POLL_BIT];
            d.st        = S_IDLE;
          end else begin
            d.prev      = cyc.rdata;
            d.have_prev = 1'b1;
          end
        end
      end
      S_READ: begin
        if (cyc.ack) begin
          d.req       = 1'b0;
          d.rsp_valid = 1'b1;
          d.rsp_rdata = cyc.rdata;
          d.rsp_error = 1'b0;
          d.st        = S_IDLE;
        end
      end
      S_RST: begin
        d.cnt = q.cnt - CNT_ONE;
        if (q.cnt == CNT_ONE) begin
          d.reset_n = 1'b1;
          d.cnt     = RH_CNT;
          d.st      = S_RST_WAIT;
        end
      end
      S_RST_WAIT: begin
        d.cnt = q.cnt - CNT_ONE;
        if (q.cnt == CNT_ONE) begin
          d.bypass    = 1'b0;
          d.rsp_valid = 1'b1;
          d.rsp_error = 1'b0;
          d.st        = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: S_IDLE, op: OP_READ, addr: '0, wdata: '0, mask: '0,
             step: '0, sec: '0, prev: '0, have_prev: 1'b0, cnt: '0,
             rsp_valid: 1'b0, rsp_rdata: '0, rsp_error: 1'b0, bypass: 1'b0,
             reset_n: 1'b1, req: 1'b0, wr: 1'b0, caddr: '0, cdata: '0};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // pin engine and outputs
  // ****************************************************************
  assign cyc.req   = q.req;
  assign cyc.wr    = q.wr;
  assign cyc.addr  = q.caddr;
  assign cyc.wdata = q.cdata;

  bus_cycle_engine u_engine (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .cyc             (cyc.engine),
    .flash_addr      (flash_addr),
    .data_lines_out  (data_lines_out),
    .data_lines_in   (data_lines_in),
    .data_lines_oe_n (data_lines_oe_n),
    .flash_ce_n      (flash_ce_n),
    .flash_we_n      (flash_we_n),
    .flash_oe_n      (flash_oe_n)
  );

  assign cmd_ready     = (q.st == S_IDLE);
  assign rsp_valid     = q.rsp_valid;
  assign rsp_rdata     = q.rsp_rdata;
  assign rsp_error     = q.rsp_error;
  assign bypass_active = q.bypass;
  assign flash_reset_n = q.reset_n;

endmodule

// ### nor_flash_host_assertions.sv
`timescale 1ns/1ps
module nor_flash_host_assertions (
  input wire logic                          mclk,            // clock
  input wire logic                          rstn,            // async reset
  input wire logic                          cmd_valid,       // request
  input wire logic                          cmd_ready,       // idle
  input wire nor_host_pkg::op_t             cmd_op,          // operation
  input wire logic [nor_host_pkg::NSEC-1:0] cmd_sector_mask, // erase sectors
  input wire logic                          rsp_valid,       // done pulse
  input wire logic                          rsp_error,       // error flag
  input wire logic                          data_lines_oe_n, // drive enable
  input wire logic                          flash_ce_n,      // chip select
  input wire logic                          flash_we_n,      // write strobe
  input wire logic                          flash_oe_n,      // read strobe
  input wire logic                          flash_reset_n    // device reset
);
  import nor_host_pkg::*;
  // ****
  // checks
  // ****
  logic [7:0] low_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // length of the device reset pulse, a counter since 63 is past repetition range
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) low_q <= 8'h00;
    else low_q <= flash_reset_n ? 8'h00 : low_q + 8'h01;
  end
  sequence s_we_pulse;
    !flash_we_n [*5] ##1 flash_we_n;
  endsequence
  sequence s_rd_pulse;
    !flash_oe_n [*8] ##1 !flash_oe_n ##1 flash_oe_n;
  endsequence
  a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and read strobe low together");
  a_read_no_drive: assert property (!flash_oe_n |-> data_lines_oe_n)
    else $error("host drives data during a read");
  a_write_setup: assert property ($fell(flash_we_n) |->
    !$past(flash_ce_n) && !$past(data_lines_oe_n)) else $error("write setup missing");
  a_we_width: assert property ($fell(flash_we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_rd_width: assert property ($fell(flash_oe_n) |-> s_rd_pulse)
    else $error("read strobe width wrong");
  a_reset_width: assert property ($rose(flash_reset_n) |-> low_q == 8'h3f)
    else $error("device reset pulse not 63 cycles");
  a_idle_standby: assert property (cmd_ready && !cmd_valid |->
    flash_ce_n && flash_we_n && flash_oe_n) else $error("strobes active while idle");
  a_zero_mask: assert property (cmd_valid && cmd_ready && cmd_op == OP_ERASE &&
    cmd_sector_mask == '0 |=> rsp_valid && rsp_error) else $error("empty erase accepted");
endmodule
bind nor_flash_host nor_flash_host_assertions u_chk (.mclk(mclk), .rstn(rstn),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .cmd_sector_mask(cmd_sector_mask), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
  .data_lines_oe_n(data_lines_oe_n), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n));

// ### nor_flash_model.sv
`timescale 1ns/1ps
module nor_flash_model #(parameter int PROT_SEC = 5, parameter int BUSY_T = 40) (
  input wire logic                        mclk,  // timing base only
  input wire logic [nor_host_pkg::AW-1:0] a,     // address lines
  input wire logic [nor_host_pkg::DW-1:0] d,     // data from host
  input wire logic                        ce_n,  // chip select
  input wire logic                        we_n,  // write strobe
  input wire logic                        oe_n,  // read strobe
  input wire logic                        rst_n, // reset pin
  output logic [nor_host_pkg::DW-1:0]     q,     // data to host
  output logic                            rdy    // ready, high when idle
);
  import nor_host_pkg::*;
  byte_t mem [faddr_t];
  byte_t p1, p2, pend, last;
  logic  prog_nx, er_arm, byp, tog;
  logic  supply_low; // set by the bench to mimic a sagging supply
  int    busy;
  initial {prog_nx, er_arm, byp, tog, busy, p1, p2, last, supply_low} = '0;
  // command decode on the strobe's rising edge; protected sectors are skipped
  always @(posedge we_n) if (!ce_n && rst_n && !supply_low) begin
    if (prog_nx) begin
      prog_nx = 0;
      if (a[21:16] != PROT_SEC) begin
        mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & d;
        pend = d;
        busy = BUSY_T;
      end
    end else if (d == 8'hf0) {er_arm, byp} = 2'b00;
    else if (d == 8'ha0 && (byp || {p2, p1} == 16'haa55)) prog_nx = 1;
    else if (d == 8'h20 && {p2, p1} == 16'haa55) byp = 1;
    else if (d == 8'h90 && byp) byp = 0;
    else if (d == 8'h80) er_arm = 1;
    else if (d == 8'h30 && er_arm && a[21:16] != PROT_SEC) begin
      for (int i = 0; i < 65536; i++) mem.delete({a[21:16], 16'h0000} + i);
      pend = 8'hff;
      busy = 4 * BUSY_T;
    end
    p2 = p1;
    p1 = d;
  end
  // algorithm timer; the reset pin aborts everything
  // falling edge, so ready and status never move at the edge the host samples
  always @(negedge mclk) begin
    if (!rst_n) {busy, prog_nx, er_arm, byp} = '0;
    else if (busy > 0) begin
      if (busy == 1) er_arm = 0;
      busy--;
    end
    if (!oe_n && !ce_n) last <= q;
  end
  // status bits while busy; released lines show the inverse of the last byte
  always @(negedge oe_n) tog = ~tog;
  assign rdy = (busy == 0);
  always @* begin
    if (ce_n || oe_n) q = ~last;
    else if (busy > 0) q = {~pend[7], tog, 6'h00};
    else q = mem.exists(a) ? mem[a] : 8'hff;
  end
endmodule

// ### nor_flash_host_bench.sv
`timescale 1ns/1ps
module nor_flash_host_bench;
  import nor_host_pkg::*;
  logic mclk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_error, bypass_active, rdy;
  logic doe_n, ce_n, we_n, oe_n, frst_n;
  op_t cmd_op;
  faddr_t cmd_addr, fa;
  byte_t cmd_wdata, rsp_rdata, dout, din;
  logic [NSEC-1:0] cmd_sector_mask;
  int failures, comparisons, cyc, wrs;
  nor_flash_host dut (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_sector_mask(cmd_sector_mask), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_error(rsp_error), .bypass_active(bypass_active), .flash_addr(fa),
    .data_lines_out(dout), .data_lines_in(din), .data_lines_oe_n(doe_n),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_reset_n(frst_n),
    .ready_busy_out(rdy));
  nor_flash_model #(.PROT_SEC(5)) u_dev (.mclk(mclk), .a(fa), .d(dout), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .rst_n(frst_n), .q(din), .rdy(rdy));
  // ****
  // clock, timeout and write-cycle counting
  // ****
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  // a hung poll loop would never end on its own
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      stop_test;
    end
  end
  always @(posedge we_n) wrs++;
  task automatic stop_test;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one operation, held until the host shows ready again, then wait for its completion pulse
  task automatic run(input op_t op, input faddr_t ad, input byte_t wd, input logic [63:0] m);
    @(negedge mclk);
    cmd_op = op;
    cmd_addr = ad;
    cmd_wdata = wd;
    cmd_sector_mask = m;
    cmd_valid = 1;
    wrs = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    cmd_valid = 0;
    while (rsp_valid !== 1'b1) @(negedge mclk);
  endtask
  // ****
  // tests
  // ****
  initial begin
    {rstn, cmd_valid, cmd_addr, cmd_wdata, cmd_sector_mask} = '0;
    {failures, comparisons, cyc} = '0;
    cmd_op = OP_READ;
    repeat (20) @(negedge mclk);
    rstn = 1;
    repeat (3) @(negedge mclk);
    check({cmd_ready, ce_n, we_n, oe_n}, 4'hf);
    run(OP_READ, 22'h010005, 8'h00, 0);
    check(rsp_rdata, 8'hff);
    run(OP_PROG, 22'h010005, 8'h3c, 0);
    check({wrs, rsp_error}, {32'd4, 1'b0});
    run(OP_PROG, 22'h050001, 8'h00, 0);
    check(rsp_error, 1'b1);
    run(OP_BYP_ENTER, UNLOCK_A1, 8'h00, 0);
    check(bypass_active, 1'b1);
    run(OP_PROG, 22'h020000, 8'h81, 0);
    check({wrs, rsp_error}, {32'd2, 1'b0});
    run(OP_PROG, 22'h3f0010, 8'h7e, 0);
    check(rsp_rdata, 8'h7e);
    run(OP_BYP_EXIT, UNLOCK_A1, 8'h00, 0);
    check(bypass_active, 1'b0);
    run(OP_ERASE, 0, 8'h00, 64'h8000_0000_0000_0002);
    check({wrs, rsp_error}, {32'd7, 1'b0});
    run(OP_READ, 22'h3f0010, 8'h00, 0);
    check(rsp_rdata, 8'hff);
    run(OP_READ, 22'h020000, 8'h00, 0);
    check(rsp_rdata, 8'h81);
    check(fa, 22'h020000);
    run(OP_READ, 22'h010005, 8'h00, 0);
    check(rsp_rdata, 8'hff);
    u_dev.supply_low = 1'b1;
    run(OP_PROG, 22'h020001, 8'h00, 0);
    check({wrs, rsp_error}, {32'd4, 1'b1});
    u_dev.supply_low = 1'b0;
    run(OP_READ, 22'h020001, 8'h00, 0);
    check(rsp_rdata, 8'hff);
    run(OP_ERASE, 0, 8'h00, 0);
    check(rsp_error, 1'b1);
    run(OP_SUSPEND, 0, 8'h00, 0);
    check({wrs, rsp_error}, {32'd1, 1'b0});
    run(OP_RESUME, 0, 8'h00, 0);
    run(OP_BYP_ENTER, UNLOCK_A1, 8'h00, 0);
    run(OP_SOFT_RESET, 0, 8'h00, 0);
    check(bypass_active, 1'b0);
    run(OP_BYP_ENTER, UNLOCK_A1, 8'h00, 0);
    run(OP_HW_RESET, 0, 8'h00, 0);
    check({bypass_active, frst_n}, 2'h1);
    stop_test;
  end
endmodule
